// ==== rtl/mdc_config_regs.sv ====
// Configuration register bank with protection response and stall blanking logic.
`default_nettype none
// How it works
// - Inrush low register holds bits 7 to 0 of blanking time.
// - Inrush high register at 0xB holds bits 15 to 8, resets zero.
// - Stall flag is suppressed while the inrush blanking timer runs.
// - Two-bit current regulation mode in bits 7 to 6, reset 1.
// - Stall response select in bit 5, reset 1.
// - Bit 4 set forces internal 500 mV reference.
// - Sense blanking 1.8 us when bit 3 is 0, 1.0 us when 1.
// - Deglitch 2 us when bit 2 is 0, 1 us when 1.
// - Overcurrent bit 0 latches outputs off until faults cleared.
// - Overcurrent bit 1 retries after a fixed retry time.
// - Overtemperature bit 0 latches outputs off on thermal shutdown.
// - Overtemperature bit 1 resumes once temperature is back below threshold.
// - Mode register at 0xC resets 0x63; report register at 0xD resets 0x38.
// - Clear faults bit clears latched faults and self clears.
// - Inrush low register at 0xA resets zero.
// - Stall report bit routes detected stall to the fault pin.
module mdc_config_regs import mdc_pkg::*; (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire mdc_wr_t    wr_i,
    input  wire logic [3:0] rd_addr_i,
    input  wire logic       motor_start_i,
    input  wire mdc_event_t evt_i,
    output logic [7:0]      rdata_o,
    output logic [1:0]      current_reg_behavior_o,
    output logic            stall_response_sel_o,
    output logic            int_vref_en_o,
    output logic [7:0]      sense_blank_cyc_o,
    output logic            outputs_off_o,
    output logic            stall_o,
    output logic            fault_pin_n_o
);
    logic [7:0]  inrush_low_ff;
    logic [7:0]  inrush_high_ff;
    logic [7:0]  mode_ff;
    logic [7:0]  report_ff;
    logic [7:0]  config0_ff;
    logic        oc_latched_ff;
    logic        ot_latched_ff;
    logic        tick_ff;
    logic [4:0]  div_ff;
    logic [7:0]  deg_len;
    logic        stall_clean;
    logic        inrush_busy;
    logic        retry_busy;
    logic        clr_pulse;
    mdc_mode_t   mode_s;

    function automatic logic wr_hit(input mdc_wr_t w, input logic [3:0] a);
        return w.write_en && (w.addr == a);
    endfunction

    assign mode_s    = mdc_mode_t'(mode_ff);
    assign clr_pulse = wr_hit(wr_i, OFS_CONFIG0) && wr_i.wdata[BIT_CLEAR_FAULTS];
    assign deg_len   = mode_s.deglitch_time_sel ? DEGLITCH_SHORT_CYC : DEGLITCH_LONG_CYC;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            inrush_low_ff  <= RST_INRUSH_LOW;
            inrush_high_ff <= RST_INRUSH_HIGH;
            mode_ff        <= RST_MODE;
            report_ff      <= RST_REPORT;
            config0_ff     <= 8'h00;
        end else begin
            if (wr_hit(wr_i, OFS_INRUSH_LOW)) begin
                inrush_low_ff <= wr_i.wdata;
            end
            if (wr_hit(wr_i, OFS_INRUSH_HIGH)) begin
                inrush_high_ff <= wr_i.wdata;
            end
            if (wr_hit(wr_i, OFS_MODE)) begin
                mode_ff <= wr_i.wdata;
            end
            if (wr_hit(wr_i, OFS_REPORT)) begin
                report_ff <= wr_i.wdata;
            end
            if (wr_hit(wr_i, OFS_CONFIG0)) begin
                config0_ff <= wr_i.wdata & ~(8'h01 << BIT_CLEAR_FAULTS);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else begin
            unique case (rd_addr_i)
                OFS_CONFIG0:     rdata_o <= config0_ff;
                OFS_INRUSH_LOW:  rdata_o <= inrush_low_ff;
                OFS_INRUSH_HIGH: rdata_o <= inrush_high_ff;
                OFS_MODE:        rdata_o <= mode_ff;
                OFS_REPORT:      rdata_o <= report_ff;
                default:         rdata_o <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            current_reg_behavior_o <= 2'h1;
            stall_response_sel_o   <= 1'b1;
            int_vref_en_o          <= 1'b0;
            sense_blank_cyc_o      <= SENSE_BLANK_LONG_CYC;
        end else begin
            current_reg_behavior_o <= mode_s.current_reg_behavior;
            stall_response_sel_o   <= mode_s.stall_response_sel;
            int_vref_en_o          <= mode_s.int_vref_en;
            sense_blank_cyc_o      <= mode_s.sense_blanking_sel ? SENSE_BLANK_SHORT_CYC
                                                                 : SENSE_BLANK_LONG_CYC;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            div_ff  <= 5'h00;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (div_ff == 5'(INRUSH_UNIT_CYC - 1));
            div_ff  <= (div_ff == 5'(INRUSH_UNIT_CYC - 1)) ? 5'h00 : div_ff + 5'h01;
        end
    end

    mdc_timer #(.W(16)) u_inrush (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .load_i  (motor_start_i),
        .count_i ({inrush_high_ff, inrush_low_ff}),
        .tick_i  (tick_ff),
        .busy_o  (inrush_busy)
    );

    mdc_timer #(.W(8)) u_retry (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .load_i  (evt_i.overcurrent && mode_s.overcurrent_response_sel),
        .count_i (RETRY_CYC),
        .tick_i  (1'b1),
        .busy_o  (retry_busy)
    );

    mdc_deglitch u_deg (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .raw_i   (evt_i.stall_raw && !inrush_busy),
        .len_i   (deg_len),
        .clean_o (stall_clean)
    );

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            oc_latched_ff <= 1'b0;
        end else if (evt_i.overcurrent && !mode_s.overcurrent_response_sel) begin
            oc_latched_ff <= 1'b1;
        end else if (clr_pulse) begin
            oc_latched_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ot_latched_ff <= 1'b0;
        end else if (evt_i.thermal) begin
            ot_latched_ff <= 1'b1;
        end else if (clr_pulse || (mode_s.overtemp_response_sel && evt_i.temp_ok)) begin
            ot_latched_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            outputs_off_o <= 1'b0;
            stall_o       <= 1'b0;
            fault_pin_n_o <= 1'b1;
        end else begin
            outputs_off_o <= oc_latched_ff || ot_latched_ff || retry_busy;
            stall_o       <= stall_clean && !inrush_busy;
            fault_pin_n_o <= !(oc_latched_ff || ot_latched_ff || retry_busy
                               || (stall_clean && report_ff[BIT_STALL_REPORT]));
        end
    end

    mode_reset_a: assert property (@(posedge mclk_i)
        $rose(rst_n_i) |-> mode_ff == RST_MODE && report_ff == RST_REPORT)
        else $error("mode or report reset value wrong");
    inrush_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_hit(wr_i, OFS_INRUSH_LOW) |=> inrush_low_ff == $past(wr_i.wdata))
        else $error("inrush low not stored");
    inrush_high_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_hit(wr_i, OFS_INRUSH_HIGH) |=> inrush_high_ff == $past(wr_i.wdata))
        else $error("inrush high not stored");
    stall_blank_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        inrush_busy |=> !stall_o)
        else $error("stall flagged during inrush");
    mode_apply_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_hit(wr_i, OFS_MODE) |=> ##1 current_reg_behavior_o == $past(wr_i.wdata[7:6], 2)
        && int_vref_en_o == $past(wr_i.wdata[4], 2))
        else $error("mode not applied");
    blank_sel_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ##1 sense_blank_cyc_o == ($past(mode_ff[3]) ? SENSE_BLANK_SHORT_CYC
                                                    : SENSE_BLANK_LONG_CYC))
        else $error("blanking count wrong");
    sequence oc_latch_s;
        evt_i.overcurrent && !mode_s.overcurrent_response_sel;
    endsequence
    sequence oc_retry_s;
        evt_i.overcurrent && mode_s.overcurrent_response_sel;
    endsequence
    sequence mode_write_s;
        wr_hit(wr_i, OFS_MODE);
    endsequence
    oc_latch_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        oc_latch_s |=> ##1 outputs_off_o)
        else $error("overcurrent not latched");
    set_wins_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        oc_latch_s and clr_pulse |=> oc_latched_ff)
        else $error("clear beat a new overcurrent");
    retry_window_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        oc_retry_s |=> ##1 outputs_off_o)
        else $error("retry window not applied");
    clear_flt_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        clr_pulse && !evt_i.overcurrent |=> !oc_latched_ff && !config0_ff[1])
        else $error("clear faults failed");
    stall_pin_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        stall_clean && report_ff[5] |=> !fault_pin_n_o)
        else $error("stall not on fault pin");
    stall_quiet_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !report_ff[5] && !oc_latched_ff && !ot_latched_ff && !retry_busy |=> fault_pin_n_o)
        else $error("stall shown on fault pin while not reported");
    ot_latch_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        evt_i.thermal |=> ot_latched_ff)
        else $error("thermal shutdown not latched");
    ot_resume_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ot_latched_ff && !evt_i.thermal && mode_ff[0] && evt_i.temp_ok |=> !ot_latched_ff)
        else $error("thermal auto resume failed");
    stall_sel_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        mode_write_s |=> ##1 stall_response_sel_o == $past(wr_i.wdata[5], 2))
        else $error("stall response not applied");
    inrush_reset_a: assert property (@(posedge mclk_i)
        $rose(rst_n_i) |-> inrush_low_ff == RST_INRUSH_LOW && inrush_high_ff == RST_INRUSH_HIGH)
        else $error("inrush reset value wrong");
    mode_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rd_addr_i == OFS_MODE |=> rdata_o == $past(mode_ff))
        else $error("mode read data wrong");
endmodule
`default_nettype wire

// ==== rtl/mdc_deglitch.sv ====
// Filter that passes a high level only after it has held for the selected number of cycles.
`default_nettype none
module mdc_deglitch import mdc_pkg::*; (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       raw_i,
    input  wire logic [7:0] len_i,
    output logic            clean_o
);
    logic [7:0] cnt_ff;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || !raw_i) begin
            cnt_ff  <= 8'h00;
            clean_o <= 1'b0;
        end else if (cnt_ff >= len_i - 8'h01) begin
            clean_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/mdc_timer.sv ====
// Down counter that reports completion of a loaded interval.
`default_nettype none
module mdc_timer import mdc_pkg::*; #(
    parameter int W = 8
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    input  wire logic         tick_i,
    output logic              busy_o
);
    logic [W-1:0] cnt_ff;
    initial begin
        if (W < 2) $error("mdc_timer width too small");
    end
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
        end else if (load_i) begin
            cnt_ff <= count_i;
        end else if (tick_i && cnt_ff != '0) begin
            cnt_ff <= cnt_ff - W'(1);
        end
    end
    assign busy_o = (cnt_ff != '0);
endmodule
`default_nettype wire

// ==== shared/mdc_pkg.sv ====
// Package with register map, field layout, reset values and timing counts of the config bank.
`default_nettype none
package mdc_pkg;
    localparam int          CLK_MHZ           = 20;
    localparam logic [3:0]  OFS_CONFIG0       = 4'h9;
    localparam logic [3:0]  OFS_INRUSH_LOW    = 4'hA;
    localparam logic [3:0]  OFS_INRUSH_HIGH   = 4'hB;
    localparam logic [3:0]  OFS_MODE          = 4'hC;
    localparam logic [3:0]  OFS_REPORT        = 4'hD;
    localparam logic [7:0]  RST_INRUSH_LOW    = 8'h00;
    localparam logic [7:0]  RST_INRUSH_HIGH   = 8'h00;
    localparam logic [7:0]  RST_MODE          = 8'h63;
    localparam logic [7:0]  RST_REPORT        = 8'h38;
    localparam int          BIT_CLEAR_FAULTS  = 1;
    localparam int          BIT_STALL_REPORT  = 5;
    localparam int          SENSE_BLANK_LONG_NS  = 1800;
    localparam int          SENSE_BLANK_SHORT_NS = 1000;
    localparam int          DEGLITCH_LONG_NS     = 2000;
    localparam int          DEGLITCH_SHORT_NS    = 1000;
    localparam int          RETRY_NS          = 4000;
    localparam int          INRUSH_UNIT_CYC   = 20;
    localparam logic [7:0]  SENSE_BLANK_LONG_CYC  = 8'((SENSE_BLANK_LONG_NS * CLK_MHZ) / 1000);
    localparam logic [7:0]  SENSE_BLANK_SHORT_CYC = 8'((SENSE_BLANK_SHORT_NS * CLK_MHZ) / 1000);
    localparam logic [7:0]  DEGLITCH_LONG_CYC     = 8'((DEGLITCH_LONG_NS * CLK_MHZ) / 1000);
    localparam logic [7:0]  DEGLITCH_SHORT_CYC    = 8'((DEGLITCH_SHORT_NS * CLK_MHZ) / 1000);
    localparam logic [7:0]  RETRY_CYC         = 8'((RETRY_NS * CLK_MHZ) / 1000);

    typedef struct packed {
        logic [1:0] current_reg_behavior;
        logic       stall_response_sel;
        logic       int_vref_en;
        logic       sense_blanking_sel;
        logic       deglitch_time_sel;
        logic       overcurrent_response_sel;
        logic       overtemp_response_sel;
    } mdc_mode_t;

    typedef struct packed {
        logic       write_en;
        logic [3:0] addr;
        logic [7:0] wdata;
    } mdc_wr_t;

    typedef struct packed {
        logic overcurrent;
        logic thermal;
        logic temp_ok;
        logic stall_raw;
    } mdc_event_t;
endpackage
`default_nettype wire

// ==== tb/mdc_config_regs_tb.sv ====
// Self-checking testbench of the configuration register bank.
`default_nettype none
module mdc_config_regs_tb import mdc_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk = 1'b0;
    logic       rst_n, motor_start, ssel, vref, off, stall, fault_n;
    logic [1:0] behav;
    logic [3:0] rd_addr;
    logic [7:0] rdata, blank, rd;
    mdc_wr_t    wr;
    mdc_event_t evt;
    int         failures = 0;
    int         samples_checked = 0;
    always #25 mclk = ~mclk;
    mdc_host_model host_u (.mclk_i(mclk), .rdata_i(rdata), .wr_o(wr), .rd_addr_o(rd_addr));
    mdc_config_regs dut_u (
        .mclk_i(mclk), .rst_n_i(rst_n), .wr_i(wr), .rd_addr_i(rd_addr),
        .motor_start_i(motor_start), .evt_i(evt), .rdata_o(rdata),
        .current_reg_behavior_o(behav), .stall_response_sel_o(ssel), .int_vref_en_o(vref),
        .sense_blank_cyc_o(blank), .outputs_off_o(off), .stall_o(stall),
        .fault_pin_n_o(fault_n));
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic rdv(input logic [3:0] a, input logic [7:0] exp, input string what);
        host_u.read(a, rd);
        check(what, rd, exp);
    endtask
    task automatic pulse_oc();
        @(negedge mclk);
        evt.overcurrent = 1'b1;
        @(negedge mclk);
        evt.overcurrent = 1'b0;
    endtask
    logic [7:0] modes [2] = '{8'h9C, 8'h43};
    initial begin
        rst_n = 1'b0;
        motor_start = 1'b0;
        evt = '0;
        wt(4);
        rst_n = 1'b1;
        check("behavior", 8'(behav), 8'h01);
        check("stall_sel", 8'(ssel), 8'h01);
        check("vref", 8'(vref), 8'h00);
        check("blank", blank, 8'h24);
        check("fault_n", 8'(fault_n), 8'h01);
        rdv(4'hA, 8'h00, "low");
        rdv(4'hB, 8'h00, "high");
        rdv(4'hC, 8'h63, "mode");
        rdv(4'hD, 8'h38, "report");
        host_u.set_inrush(16'hA55A);
        host_u.write(4'hE, 8'hFF);
        rdv(4'hA, 8'h5A, "low");
        rdv(4'hB, 8'hA5, "high");
        rdv(4'hE, 8'h00, "unmapped");
        foreach (modes[i]) begin
            host_u.write(4'hC, modes[i]);
            wt(2);
            check("behavior", 8'(behav), 8'(modes[i][7:6]));
            check("stall_sel", 8'(ssel), 8'(modes[i][5]));
            check("vref", 8'(vref), 8'(modes[i][4]));
            check("blank", blank, modes[i][3] ? 8'h14 : 8'h24);
            rdv(4'hC, modes[i], "mode");
        end
        evt.temp_ok = 1'b1;
        host_u.write(4'hC, 8'h60);
        pulse_oc();
        wt(100);
        check("oc latch", 8'(off), 8'h01);
        host_u.write(4'h9, 8'h02);
        wt(2);
        check("cleared", 8'(off), 8'h00);
        rdv(4'h9, 8'h00, "clear bit");
        evt.thermal = 1'b1;
        wt(1);
        evt.thermal = 1'b0;
        wt(20);
        check("ot latch", 8'(off), 8'h01);
        host_u.write(4'h9, 8'h02);
        host_u.write(4'hC, 8'h63);
        wt(2);
        pulse_oc();
        wt(40);
        check("retry on", 8'(off), 8'h01);
        wt(60);
        check("retry off", 8'(off), 8'h00);
        evt = 4'h4;
        wt(10);
        evt.temp_ok = 1'b0;
        evt.thermal = 1'b0;
        wt(10);
        check("ot off", 8'(off), 8'h01);
        evt.temp_ok = 1'b1;
        wt(5);
        check("ot resume", 8'(off), 8'h00);
        host_u.set_inrush(16'h0004);
        motor_start = 1'b1;
        evt.stall_raw = 1'b1;
        wt(1);
        motor_start = 1'b0;
        wt(60);
        check("blanked", 8'(stall), 8'h00);
        wt(75);
        check("stall", 8'(stall), 8'h01);
        check("fault_n", 8'(fault_n), 8'h00);
        host_u.write(4'hD, 8'h18);
        wt(2);
        check("no report", 8'(fault_n), 8'h01);
        host_u.write(4'hC, 8'h67);
        evt.stall_raw = 1'b0;
        wt(5);
        evt.stall_raw = 1'b1;
        wt(14);
        check("short deg", 8'(stall), 8'h00);
        wt(10);
        check("short deg", 8'(stall), 8'h01);
        conclude();
    end
    initial begin
        wt(5000);
        failures++;
        conclude();
    end
endmodule
`default_nettype wire

// ==== tb/mdc_host_model.sv ====
// Host model that writes and reads the configuration bank.
`default_nettype none
module mdc_host_model import mdc_pkg::*; (
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    output var mdc_wr_t     wr_o,
    output logic [3:0]      rd_addr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        wr_o      = '0;
        rd_addr_o = 4'h0;
    end
    task automatic write(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        wr_o <= '{1'b1, a, d};
        @(negedge mclk_i);
        wr_o.write_en <= 1'b0;
    endtask
    task automatic read(input logic [3:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        rd_addr_o <= a;
        @(negedge mclk_i);
        d = rdata_i;
    endtask
    // Both halves are written before the motor is started.
    task automatic set_inrush(input logic [15:0] t);
        write(OFS_INRUSH_LOW, t[7:0]);
        write(OFS_INRUSH_HIGH, t[15:8]);
    endtask
endmodule
`default_nettype wire
